// File: irt_consts.vh
`ifndef IRT_CONSTS_VH
`define IRT_CONSTS_VH
// register indices
`define IRT_ADDR_TIMER 3'h0
`define IRT_ADDR_CTL_FIRST 3'h3
`define IRT_ADDR_CTL_SECOND 3'h4
`define IRT_ADDR_STATUS 3'h5
`define IRT_ADDR_STANDBY 3'h6
// reset values
`define IRT_CTL_FIRST_RST 8'h03
`define IRT_CTL_SECOND_RST 8'h26
// first control register fields
`define IRT_F_CSEL_LO 0
`define IRT_F_CSEL_HI 1
`define IRT_F_CARRIER_DISABLE 2
`define IRT_F_CLOCK_HALVER 3
// second control register fields
`define IRT_F_SENSE_A_IN 0
`define IRT_F_KEY_SCAN_OUT 1
`define IRT_F_INDICATOR_MODE 2
`define IRT_F_SENSE_PULL 4
`define IRT_F_KEY_IN_PULL 5
`define IRT_CTL_SECOND_MASK 8'h37
// timer
`define IRT_TIMER_BITS 9
`define IRT_F_TIMER_OE 9
`define IRT_TICK_DIV 64
// carrier periods and high widths in fx periods, before halving
`define IRT_CAR_PER_8 8
`define IRT_CAR_PER_64 64
`define IRT_CAR_PER_96 96
`define IRT_CAR_HI_8 4
`define IRT_CAR_HI_64 32
`define IRT_CAR_HI_96 48
`define IRT_CAR_HI_96_THIRD 32
// standby operand codes
`define IRT_OP_HALT_TIMER 3'h5
`define IRT_OP_STOP_A 3'h0
`define IRT_OP_STOP_B 3'h3
`define IRT_OP_STOP_C 3'h6
`endif

// File: irt_carrier_timer.v
`timescale 1ns/1ns
`include "irt_consts.vh"
module irt_carrier_timer #(
  parameter TIMER_BITS = `IRT_TIMER_BITS,
  parameter KEY_SCAN_W = 8,
  parameter KEY_IN_W = 4
)(
  input wire clk,
  input wire rst,
  input wire [2:0] addr,
  input wire [9:0] wdata,
  input wire wr,
  input wire rd,
  output reg [9:0] rdata_ff,
  input wire [KEY_IN_W-1:0] key_input_port,
  input wire sense_input_a,
  input wire sense_indicator_in,
  output reg sense_indicator_out_ff,
  output reg sense_indicator_oe_ff,
  output reg sense_a_input_en_ff,
  output reg sense_pull_a_ff,
  output reg sense_pull_ind_ff,
  output reg [KEY_SCAN_W-1:0] key_scan_oe_ff,
  output reg key_input_pull_ff,
  output reg infrared_out_pin_ff,
  output reg timer_end_ff,
  output reg cpu_halted_ff,
  output reg osc_hold_low_ff,
  output reg status_flag_ff
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [7:0] port_control_first_ff;
  reg [7:0] port_control_second_ff;
  wire [1:0] carrier_sel;
  wire carrier_disable;
  wire timer_clock_halver;

  assign carrier_sel = port_control_first_ff[`IRT_F_CSEL_HI:`IRT_F_CSEL_LO];
  assign carrier_disable = port_control_first_ff[`IRT_F_CARRIER_DISABLE];
  assign timer_clock_halver = port_control_first_ff[`IRT_F_CLOCK_HALVER];
  always @(posedge clk)
  begin
    if (rst)
    begin
      port_control_first_ff <= `IRT_CTL_FIRST_RST;
      port_control_second_ff <= `IRT_CTL_SECOND_RST;
    end
    else if (wr)
    begin
      if (addr == `IRT_ADDR_CTL_FIRST)
        port_control_first_ff <= {4'h0, wdata[3:0]};
      if (addr == `IRT_ADDR_CTL_SECOND)
        port_control_second_ff <= wdata[7:0] & `IRT_CTL_SECOND_MASK;
    end
  end

  // ----------------------------------------------------------------
  // standby state
  // ----------------------------------------------------------------
  localparam ST_RUN = 2'd0;
  localparam ST_HALT = 2'd1;
  localparam ST_STOP_WAIT = 2'd2;
  localparam ST_STOP = 2'd3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [3:0] sb_op_ff;
  reg [3:0] nxt_sb_op;
  reg nxt_flag;
  reg nxt_halted;
  reg nxt_osc_low;

  // ----------------------------------------------------------------
  // timer: prescaler, down counter, output enable
  // ----------------------------------------------------------------
  reg [6:0] pre_ff;
  reg [TIMER_BITS-1:0] cnt_ff;
  reg timer_oe_ff;
  wire tick;
  wire running;
  wire timer_wr;
  wire stop_clear;

  // the prescaler runs free, so a load is not phase-aligned to a tick
  assign tick = timer_clock_halver ? (pre_ff == 7'h7f) : (pre_ff[5:0] == 6'h3f);
  assign running = (cnt_ff != {TIMER_BITS{1'b0}});
  assign timer_wr = wr && (addr == `IRT_ADDR_TIMER);
  // entering stop clears the nine-bit count and its output enable; the prescaler keeps running
  assign stop_clear = (state_ff == ST_STOP_WAIT);
  always @(posedge clk)
  begin
    if (rst)
      pre_ff <= 7'h00;
    else
      pre_ff <= pre_ff + 7'h01;
  end
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= {TIMER_BITS{1'b0}};
      timer_oe_ff <= 1'b0;
    end
    else if (stop_clear)
    begin
      cnt_ff <= {TIMER_BITS{1'b0}};
      timer_oe_ff <= 1'b0;
    end
    else if (timer_wr)
    begin
      // any non-zero value starts the count at once
      cnt_ff <= wdata[TIMER_BITS-1:0];
      timer_oe_ff <= wdata[`IRT_F_TIMER_OE];
    end
    else if (tick && running)
      cnt_ff <= cnt_ff - {{(TIMER_BITS-1){1'b0}}, 1'b1};
  end

  // ----------------------------------------------------------------
  // carrier generator
  // ----------------------------------------------------------------
  reg [8:0] car_cnt_ff;
  reg [8:0] car_per;
  reg [8:0] car_hi;
  wire [8:0] car_per_eff;
  wire [8:0] car_hi_eff;
  wire carrier_high;

  always @*
  begin
    case (carrier_sel)
      2'd0:
      begin
        car_per = 9'd`IRT_CAR_PER_8;
        car_hi = 9'd`IRT_CAR_HI_8;
      end
      2'd1:
      begin
        car_per = 9'd`IRT_CAR_PER_64;
        car_hi = 9'd`IRT_CAR_HI_64;
      end
      2'd2:
      begin
        car_per = 9'd`IRT_CAR_PER_96;
        car_hi = 9'd`IRT_CAR_HI_96;
      end
      default:
      begin
        car_per = 9'd`IRT_CAR_PER_96;
        car_hi = 9'd`IRT_CAR_HI_96_THIRD;
      end
    endcase
  end

  assign car_per_eff = timer_clock_halver ? {car_per[7:0], 1'b0} : car_per;
  assign car_hi_eff = timer_clock_halver ? {car_hi[7:0], 1'b0} : car_hi;
  // high phase sits at the end of the period, so a select change cannot
  // leave the counter past the wrap point for long
  assign carrier_high = (car_cnt_ff >= (car_per_eff - car_hi_eff));

  // free running: the first high phase after a start may be cut short
  always @(posedge clk)
  begin
    if (rst)
      car_cnt_ff <= 9'h000;
    else if (car_cnt_ff >= (car_per_eff - 9'h001))
      car_cnt_ff <= 9'h000;
    else
      car_cnt_ff <= car_cnt_ff + 9'h001;
  end

  // ----------------------------------------------------------------
  // infrared gate with carrier synchroniser
  // ----------------------------------------------------------------
  reg ir_gate_ff;
  wire ir_active;
  reg nxt_ir;

  assign ir_active = running && timer_oe_ff;
  always @(posedge clk)
  begin
    if (rst)
      ir_gate_ff <= 1'b0;
    else if (ir_active)
      ir_gate_ff <= 1'b1;
    else if (carrier_disable || !carrier_high)
      ir_gate_ff <= 1'b0;
  end

  always @*
  begin
    nxt_ir = 1'b0;
    if (ir_active || ir_gate_ff)
    begin
      if (carrier_disable)
        nxt_ir = ir_active;
      else
        nxt_ir = carrier_high;
    end
  end

  // ----------------------------------------------------------------
  // standby control
  // ----------------------------------------------------------------
  wire sb_req;
  wire key_high;
  wire sense_high;
  reg op_valid;
  reg release_met;
  reg [3:0] rel_op;
  wire sw_flag_wr;

  assign sb_req = wr && (addr == `IRT_ADDR_STANDBY) && (state_ff == ST_RUN);
  assign sw_flag_wr = wr && (addr == `IRT_ADDR_STATUS);
  assign key_high = |key_input_port;
  // a sense pin may wake the part only in input mode
  assign sense_high =
    (sense_input_a && port_control_second_ff[`IRT_F_SENSE_A_IN]) ||
    (sense_indicator_in && !port_control_second_ff[`IRT_F_INDICATOR_MODE]);

  always @*
  begin
    rel_op = (state_ff == ST_RUN) ? wdata[3:0] : sb_op_ff;
    op_valid = 1'b1;
    release_met = 1'b0;
    case (rel_op[2:0])
      `IRT_OP_HALT_TIMER: release_met = !running;
      `IRT_OP_STOP_A,
      `IRT_OP_STOP_B,
      `IRT_OP_STOP_C: release_met = key_high || (rel_op[3] && sense_high);
      default: op_valid = 1'b0;
    endcase
  end

  always @*
  begin
    nxt_state = state_ff;
    nxt_sb_op = sb_op_ff;
    nxt_flag = status_flag_ff;
    nxt_halted = 1'b0;
    nxt_osc_low = 1'b0;
    if (sw_flag_wr)
      nxt_flag = wdata[0];
    case (state_ff)
      ST_RUN:
      begin
        if (sb_req && op_valid)
        begin
          if (status_flag_ff)
            nxt_flag = release_met;
          else if (release_met)
            nxt_flag = 1'b1;
          else
          begin
            nxt_sb_op = wdata[3:0];
            if (wdata[2:0] == `IRT_OP_HALT_TIMER)
              nxt_state = ST_HALT;
            else
              nxt_state = ST_STOP_WAIT;
          end
        end
      end
      ST_HALT:
      begin
        if (release_met)
        begin
          nxt_state = ST_RUN;
          nxt_flag = 1'b1;
        end
      end
      ST_STOP_WAIT:
        if (!running && !timer_oe_ff)
          nxt_state = ST_STOP;
      ST_STOP:
      begin
        if (release_met)
        begin
          nxt_state = ST_RUN;
          nxt_flag = 1'b1;
        end
      end
      default:
        nxt_state = ST_RUN;
    endcase
    nxt_halted = (nxt_state != ST_RUN);
    nxt_osc_low = (nxt_state == ST_STOP);
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= ST_RUN;
      sb_op_ff <= 4'h0;
      status_flag_ff <= 1'b0;
      cpu_halted_ff <= 1'b0;
      osc_hold_low_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sb_op_ff <= nxt_sb_op;
      status_flag_ff <= nxt_flag;
      cpu_halted_ff <= nxt_halted;
      osc_hold_low_ff <= nxt_osc_low;
    end
  end

  // ----------------------------------------------------------------
  // pin controls
  // ----------------------------------------------------------------
  wire sense_a_in;
  wire ind_mode;

  assign sense_a_in = port_control_second_ff[`IRT_F_SENSE_A_IN];
  assign ind_mode = port_control_second_ff[`IRT_F_INDICATOR_MODE];
  always @(posedge clk)
  begin
    if (rst)
    begin
      sense_indicator_out_ff <= 1'b1;
      sense_indicator_oe_ff <= 1'b1;
      sense_a_input_en_ff <= 1'b0;
      sense_pull_a_ff <= 1'b0;
      sense_pull_ind_ff <= 1'b0;
      key_scan_oe_ff <= {KEY_SCAN_W{1'b1}};
      key_input_pull_ff <= 1'b1;
      infrared_out_pin_ff <= 1'b0;
      timer_end_ff <= 1'b1;
    end
    else
    begin
      sense_indicator_out_ff <= !ir_active;
      sense_indicator_oe_ff <= ind_mode;
      sense_a_input_en_ff <= sense_a_in;
      sense_pull_a_ff <= port_control_second_ff[`IRT_F_SENSE_PULL] && sense_a_in;
      sense_pull_ind_ff <= port_control_second_ff[`IRT_F_SENSE_PULL] && !ind_mode;
      key_scan_oe_ff <= {KEY_SCAN_W{port_control_second_ff[`IRT_F_KEY_SCAN_OUT]}};
      key_input_pull_ff <= port_control_second_ff[`IRT_F_KEY_IN_PULL];
      infrared_out_pin_ff <= nxt_ir;
      timer_end_ff <= !running;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  reg [9:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = 10'h000;
    case (addr)
      `IRT_ADDR_TIMER: nxt_rdata = {timer_oe_ff, cnt_ff};
      `IRT_ADDR_CTL_FIRST: nxt_rdata = {2'b00, port_control_first_ff};
      `IRT_ADDR_CTL_SECOND: nxt_rdata = {2'b00, port_control_second_ff};
      `IRT_ADDR_STATUS: nxt_rdata = {5'h00, state_ff, ir_gate_ff, !running, status_flag_ff};
      default: nxt_rdata = 10'h000;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst || !rd)
      rdata_ff <= 10'h000;
    else
      rdata_ff <= nxt_rdata;
  end

endmodule // irt_carrier_timer

// File: irt_led_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// infrared emitter and indicator lamp
// ----------------------------------------
module irt_led_model (
  input logic clk,
  input logic ir,
  input logic drive,
  input logic oe,
  input logic pull,
  input logic press,
  output logic level,
  output int lit_cnt_ff
);
  logic last_ff = 1'b0;
  initial lit_cnt_ff = 0;
  // a floating pin shows the inverse of its last level, so a stale value never reads as good
  assign level = oe ? drive : (press | (pull ? 1'b0 : ~last_ff));
  always @(posedge clk)
  begin
    last_ff <= level;
    if (ir === 1'b1)
      lit_cnt_ff <= lit_cnt_ff + 1;
  end
endmodule // irt_led_model

// File: irt_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// pin and bus relations
// ----------------------------------------
module irt_checker #(
  parameter KEY_SCAN_W = 8
)(
  input logic clk,
  input logic rst,
  input logic [2:0] addr,
  input logic [9:0] wdata,
  input logic wr,
  input logic rd,
  input logic [9:0] rdata_ff,
  input logic sense_a_input_en_ff,
  input logic sense_pull_a_ff,
  input logic sense_indicator_oe_ff,
  input logic sense_pull_ind_ff,
  input logic sense_indicator_out_ff,
  input logic [KEY_SCAN_W-1:0] key_scan_oe_ff,
  input logic key_input_pull_ff,
  input logic infrared_out_pin_ff,
  input logic timer_end_ff,
  input logic cpu_halted_ff,
  input logic osc_hold_low_ff,
  input logic status_flag_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_PULL_A: assert property (!sense_a_input_en_ff |-> !sense_pull_a_ff)
    else $error("sense pull-down on in off mode");
  AST_PULL_IND: assert property (sense_indicator_oe_ff |-> !sense_pull_ind_ff)
    else $error("indicator pull-down on in output mode");
  AST_KEY_CFG: assert property (wr && addr == 3'h4 |-> ##2
    key_scan_oe_ff == {KEY_SCAN_W{$past(wdata[1], 2)}} && key_input_pull_ff == $past(wdata[5], 2))
    else $error("key port setup does not follow control write");
  AST_START: assert property (wr && addr == 3'h0 && wdata[8:1] != 8'h00 |-> ##2 !timer_end_ff)
    else $error("timer did not start");
  AST_END: assert property (wr && addr == 3'h0 && wdata[8:0] == 9'h003 |=> ##[128:400] timer_end_ff)
    else $error("timer end missing");
  AST_IND: assert property (timer_end_ff |-> sense_indicator_out_ff)
    else $error("indicator low while stopped");
  AST_IR_HOLD: assert property (timer_end_ff && !infrared_out_pin_ff |=>
    !infrared_out_pin_ff || !timer_end_ff)
    else $error("infrared rose while stopped");
  AST_READ: assert property (!$past(rd) |-> rdata_ff == 10'h000)
    else $error("read data outside its cycle");
  AST_OSC: assert property (osc_hold_low_ff |-> cpu_halted_ff)
    else $error("oscillator held without standby");
  AST_REFUSE: assert property (wr && addr == 3'h6 && status_flag_ff && !cpu_halted_ff
    |=> !cpu_halted_ff [*2])
    else $error("standby entered with flag set");
endmodule // irt_checker
bind irt_carrier_timer irt_checker #(.KEY_SCAN_W(KEY_SCAN_W)) u_irt_checker (.clk, .rst, .addr,
  .wdata, .wr, .rd, .rdata_ff, .sense_a_input_en_ff, .sense_pull_a_ff, .sense_indicator_oe_ff,
  .sense_pull_ind_ff, .sense_indicator_out_ff, .key_scan_oe_ff, .key_input_pull_ff,
  .infrared_out_pin_ff, .timer_end_ff, .cpu_halted_ff, .osc_hold_low_ff, .status_flag_ff);

// File: tb.sv
`timescale 1ns/1ns
`include "irt_consts.vh"
// ----------------------------------------
// register and pin sequences
// ----------------------------------------
module tb;
  logic clk, rst, wr, rd, sense_input_a, press;
  logic [2:0] addr;
  logic [9:0] wdata, got;
  logic [3:0] key_input_port;
  wire [9:0] rdata_ff;
  wire [7:0] key_scan_oe_ff;
  wire sense_indicator_in, sense_indicator_out_ff, sense_indicator_oe_ff, sense_a_input_en_ff;
  wire sense_pull_a_ff, sense_pull_ind_ff, key_input_pull_ff, infrared_out_pin_ff;
  wire timer_end_ff, cpu_halted_ff, osc_hold_low_ff, status_flag_ff;
  int fail_count, checks_done, cyc, n, m, lit;
  int hi_w[5] = '{`IRT_CAR_HI_8, `IRT_CAR_HI_64, `IRT_CAR_HI_96, `IRT_CAR_HI_96_THIRD, 8};
  int per_w[5] = '{`IRT_CAR_PER_8, `IRT_CAR_PER_64, `IRT_CAR_PER_96, `IRT_CAR_PER_96, 16};
  logic [2:0] ops[3] = '{`IRT_OP_STOP_A, `IRT_OP_STOP_B, `IRT_OP_STOP_C};
  irt_carrier_timer i_irt_carrier_timer (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata_ff,
    .key_input_port, .sense_input_a, .sense_indicator_in, .sense_indicator_out_ff,
    .sense_indicator_oe_ff, .sense_a_input_en_ff, .sense_pull_a_ff, .sense_pull_ind_ff,
    .key_scan_oe_ff, .key_input_pull_ff, .infrared_out_pin_ff, .timer_end_ff, .cpu_halted_ff,
    .osc_hold_low_ff, .status_flag_ff);
  irt_led_model i_irt_led_model (.clk, .ir(infrared_out_pin_ff), .drive(sense_indicator_out_ff),
    .oe(sense_indicator_oe_ff), .pull(sense_pull_ind_ff), .press, .level(sense_indicator_in),
    .lit_cnt_ff(lit));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [9:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata_ff;
  endtask
  function logic pick(input int w);
    return w == 0 ? infrared_out_pin_ff : (w == 1 ? cpu_halted_ff : osc_hold_low_ff);
  endfunction
  // bounded wait; n returns the cycles spent
  task wait_on(input int w, input logic v);
    n = 0;
    while (pick(w) !== v && n < 2000)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 2000)
      fail_count++;
  endtask
  task pins(input logic [9:0] exp);
    chk({sense_indicator_oe_ff, sense_a_input_en_ff, key_input_pull_ff, sense_pull_a_ff,
      sense_pull_ind_ff}, exp);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // the whole sequence needs well under 20000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 3'h0; wdata = 10'h000; press = 1'b0;
    key_input_port = 4'h0; sense_input_a = 1'b0; fail_count = 0; checks_done = 0; cyc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`IRT_ADDR_CTL_SECOND); chk(got, 10'h026);
    pins(10'h014); chk(key_scan_oe_ff, 10'h0ff);
    wr_reg(`IRT_ADDR_CTL_SECOND, 10'h0ff); rd_reg(`IRT_ADDR_CTL_SECOND); chk(got, 10'h037);
    pins(10'h01e); chk(key_scan_oe_ff, 10'h0ff);
    wr_reg(`IRT_ADDR_CTL_SECOND, 10'h010); rd_reg(3'h7); chk(got, 10'h000);
    pins(10'h001); chk(key_scan_oe_ff, 10'h000);
    wr_reg(`IRT_ADDR_CTL_SECOND, 10'h031); rd_reg(3'h7); pins(10'h00f);
    wr_reg(`IRT_ADDR_CTL_SECOND, 10'h026);
    for (int h = 0; h < 2; h++)
    begin
      wr_reg(`IRT_ADDR_CTL_FIRST, h ? 10'h00c : 10'h004);
      m = lit; wr_reg(`IRT_ADDR_TIMER, 10'h203); repeat (10) @(posedge clk); #1;
      chk({sense_indicator_out_ff, timer_end_ff, infrared_out_pin_ff}, 10'h001);
      wait_on(0, 1'b0); n = lit - m;
      chk(n >= 128 * (h + 1) + 1 && n <= 192 * (h + 1), 10'h001);
      chk(sense_indicator_out_ff, 10'h001);
    end
    m = lit; wr_reg(`IRT_ADDR_TIMER, 10'h300); wr_reg(`IRT_ADDR_TIMER, 10'h000);
    repeat (3) @(posedge clk); chk(lit - m, 10'h002);
    for (int s = 0; s < 5; s++)
    begin
      wr_reg(`IRT_ADDR_CTL_FIRST, s < 4 ? s : 10'h008); wr_reg(`IRT_ADDR_TIMER, 10'h20a);
      wait_on(0, 1'b0); wait_on(0, 1'b1); wait_on(0, 1'b0); wait_on(0, 1'b1);
      wait_on(0, 1'b0); chk(n, hi_w[s]); m = n;
      wait_on(0, 1'b1); chk(n + m, per_w[s]);
      wr_reg(`IRT_ADDR_TIMER, 10'h000); wait_on(0, 1'b0);
      chk(n >= hi_w[s] - 3 && n <= hi_w[s] - 1, 10'h001);
    end
    wr_reg(`IRT_ADDR_CTL_FIRST, 10'h004); wr_reg(`IRT_ADDR_STATUS, 10'h000);
    wr_reg(`IRT_ADDR_TIMER, 10'h203); wr_reg(`IRT_ADDR_STANDBY, 10'h005);
    wait_on(1, 1'b1); chk({cpu_halted_ff, infrared_out_pin_ff}, 10'h003);
    wait_on(1, 1'b0); rd_reg(`IRT_ADDR_STATUS); chk(got & 10'h003, 10'h003);
    wr_reg(`IRT_ADDR_TIMER, 10'h203); wr_reg(`IRT_ADDR_STANDBY, 10'h005);
    rd_reg(`IRT_ADDR_STATUS); chk({cpu_halted_ff, got[0]}, 10'h000);
    wait_on(0, 1'b0); wr_reg(`IRT_ADDR_STANDBY, 10'h005);
    rd_reg(`IRT_ADDR_STATUS); chk({cpu_halted_ff, got[0]}, 10'h001);
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(`IRT_ADDR_STATUS, 10'h000); wr_reg(`IRT_ADDR_TIMER, 10'h210);
      wr_reg(`IRT_ADDR_STANDBY, {7'h00, ops[k]});
      wait_on(2, 1'b1); chk({osc_hold_low_ff, infrared_out_pin_ff}, 10'h002);
      @(posedge clk); key_input_port <= 4'h1;
      wait_on(1, 1'b0); chk(osc_hold_low_ff, 10'h000);
      @(posedge clk); key_input_port <= 4'h0;
      rd_reg(`IRT_ADDR_TIMER); chk(got, 10'h000);
      rd_reg(`IRT_ADDR_STATUS); chk(got & 10'h003, 10'h003);
    end
    tally_and_finish;
  end
endmodule // tb
